//--- urx_pkg.sv
// urx_pkg: constants and carrier types of the receive-side cell bus slave.
// assumes: included before every module of the block.
`default_nettype none
package urx_pkg;

  // widths of the local word path and the cell bus
  localparam int unsigned URX_ADDR_W    = 5;
  localparam int unsigned URX_WORD_W    = 32;
  localparam int unsigned URX_BUS_W     = 16;
  localparam int unsigned URX_BYTE_W    = 8;
  localparam int unsigned URX_CNT_W     = 6;
  localparam int unsigned URX_LANE_W    = 2;

  // cell length in bus units per width mode
  localparam logic [5:0]  URX_CELL_BYTES = 6'h35;  // 53 bytes
  localparam logic [5:0]  URX_CELL_HALFS = 6'h1b;  // 27 half-words

  // bus units per fetched word, minus one
  localparam logic [1:0]  URX_LAST_LANE8  = 2'h3;
  localparam logic [1:0]  URX_LAST_LANE16 = 2'h1;

  // reset values
  localparam logic [5:0]  URX_CNT_RST   = 6'h00;
  localparam logic [1:0]  URX_LANE_RST  = 2'h0;
  localparam logic [15:0] URX_DATA_RST  = 16'h0000;

  // synchroniser depth
  localparam int unsigned URX_SYNC_STAGES = 2;

  // one word as fetched from the cell fifo
  typedef struct packed {
    logic [31:0] data;
    logic        soc;
    logic        eoc;
  } urx_word_t;

  localparam urx_word_t URX_WORD_RST = '{data: 32'h0000_0000, soc: 1'b0, eoc: 1'b0};

endpackage
`default_nettype wire

//--- urx_sync.sv
// urx_sync: two-stage level synchroniser, one per bit.
// assumes: inputs are levels that stay stable for at least two dest clocks.
`timescale 1ns/1ps
`default_nettype none
module urx_sync
  import urx_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

//--- urx_slave.sv
// urx_slave: receive-side cell bus slave; fetches cell words from a local
// fifo on clk_in and sends them as bytes or half-words on the link clock.
// assumes: fifo is show-ahead (word valid while its read is high), fifo
// signals are on clk_in; port address and width select are static.
//
// Functional notes
// - clav output high when addressed port holds a complete cell.
// - separate active-high hiz control for clav, low enables it.
// - master's active-low enable gates transfer; data moves only while low.
// - start-of-cell output marks the first unit of each cell.
// - one odd parity bit per unit over the active data lines.
// - active-high hiz control for soc, data and parity outputs.
// - active-high read pulse fetches each 32-bit fifo word.
// - takes 5-bit bus address and static 5-bit own port address.
// - one-cycle total-cell pulse at start of each cell transfer.
// - underrun high when port selected and enable low while fifo holds no cell.
// - width select: one gives 16-bit bus, zero 8-bit low byte.
// - reset returns all state asynchronously to initial values.
// - 16-bit data output, only low byte used in 8-bit mode.
`timescale 1ns/1ps
`default_nettype none
module urx_slave
  import urx_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        fifo_clav_in,
  input  wire logic [31:0] fifo_data_in,
  input  wire logic        fifo_soc_in,
  input  wire logic        fifo_eoc_in,
  output logic             fifo_read_out,
  input  wire logic        link_clk_in,
  input  wire logic [4:0]  link_addr_in,
  input  wire logic        link_enb_n_in,
  input  wire logic [4:0]  port_addr_in,
  input  wire logic        wide_bus_in,
  output logic             link_clav_out,
  output logic             clav_hiz_out,
  output logic             link_soc_out,
  output logic [15:0]      link_data_out,
  output logic             link_parity_out,
  output logic             bus_outputs_hiz_out,
  output logic             total_cell_out,
  output logic             underrun_out
);

  // ---------------- local clock domain: fifo fetch ----------------

  urx_word_t word_reg;
  urx_word_t word_next;
  logic      req_tgl_reg;
  logic      req_tgl_next;
  logic      in_cell_reg;
  logic      in_cell_next;
  logic      ack_tgl_s;
  logic      can_read;
  logic      waiting_reg;
  logic      waiting_next;

  // ack toggle returning from the link side
  logic      ack_tgl_reg;

  urx_sync #(
    .WIDTH (1)
  ) u_ack_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (ack_tgl_reg),
    .sync_out  (ack_tgl_s)
  );

  // read when idle
  // a word is fetched only when the previous one was taken by the link
  always_comb begin
    can_read     = (req_tgl_reg == ack_tgl_s) && (in_cell_reg || fifo_clav_in);
    word_next    = word_reg;
    req_tgl_next = req_tgl_reg;
    in_cell_next = in_cell_reg;
    if (can_read) begin
      word_next.data = fifo_data_in;
      word_next.soc  = fifo_soc_in;
      word_next.eoc  = fifo_eoc_in;
      req_tgl_next   = ~req_tgl_reg;
      in_cell_next   = ~fifo_eoc_in;  // keep fetching until the last word
    end
    waiting_next = fifo_clav_in || in_cell_next;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      word_reg    <= URX_WORD_RST;
      req_tgl_reg <= 1'b0;
      in_cell_reg <= 1'b0;
      waiting_reg <= 1'b0;
    end else begin
      word_reg    <= word_next;
      req_tgl_reg <= req_tgl_next;
      in_cell_reg <= in_cell_next;
      waiting_reg <= waiting_next;
    end
  end

  assign fifo_read_out = can_read;

  // ---------------- crossings into the link domain ----------------

  logic       req_tgl_s;
  logic       clav_s;
  logic       wide_s;
  logic [4:0] port_s;
  logic       cell_waiting;

  // a cell counts as waiting while the fifo says so or one is in flight;
  // taken from a flop so the synchroniser never sees a gate glitch
  assign cell_waiting = waiting_reg;

  urx_sync #(
    .WIDTH (1)
  ) u_req_sync (
    .clk_in    (link_clk_in),
    .resetn_in (resetn_in),
    .async_in  (req_tgl_reg),
    .sync_out  (req_tgl_s)
  );

  urx_sync #(
    .WIDTH (1)
  ) u_clav_sync (
    .clk_in    (link_clk_in),
    .resetn_in (resetn_in),
    .async_in  (cell_waiting),
    .sync_out  (clav_s)
  );

  urx_sync #(
    .WIDTH (URX_ADDR_W + 1)
  ) u_cfg_sync (
    .clk_in    (link_clk_in),
    .resetn_in (resetn_in),
    .async_in  ({wide_bus_in, port_addr_in}),
    .sync_out  ({wide_s, port_s})
  );

  // ---------------- link domain: poll, select, send ----------------

  logic        clav_reg;
  logic        clav_next;
  logic        clav_hiz_reg;
  logic        clav_hiz_next;
  logic        sel_reg;
  logic        sel_next;
  logic        out_hiz_reg;
  logic        out_hiz_next;
  logic        soc_reg;
  logic        soc_next;
  logic [15:0] data_reg;
  logic [15:0] data_next;
  logic        parity_reg;
  logic        parity_next;
  logic        total_reg;
  logic        total_next;
  logic        underrun_reg;
  logic        underrun_next;
  logic        ack_tgl_next;
  logic [1:0]  lane_reg;
  logic [1:0]  lane_next;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;

  logic        addr_match;
  logic        word_avail;
  logic        go;
  logic [1:0]  last_lane;
  logic [5:0]  last_unit;
  logic [15:0] unit;
  logic        cell_end;

  assign addr_match = (link_addr_in == port_s);
  // word_reg is stable while the request toggle differs from the ack
  assign word_avail = (req_tgl_s != ack_tgl_reg);

  always_comb begin
    if (wide_s) begin
      last_lane = URX_LAST_LANE16;
      last_unit = URX_CELL_HALFS - 6'h01;
    end else begin
      last_lane = URX_LAST_LANE8;
      last_unit = URX_CELL_BYTES - 6'h01;
    end
  end

  always_comb begin
    unit = URX_DATA_RST;
    if (wide_s) begin
      unit = lane_reg[0] ? word_reg.data[15:0] : word_reg.data[31:16];
    end else begin
      case (lane_reg)
        2'h0:    unit = {8'h00, word_reg.data[31:24]};
        2'h1:    unit = {8'h00, word_reg.data[23:16]};
        2'h2:    unit = {8'h00, word_reg.data[15:8]};
        default: unit = {8'h00, word_reg.data[7:0]};
      endcase
    end
  end

  assign go       = sel_reg && !link_enb_n_in && word_avail;
  assign cell_end = (cnt_reg == last_unit);

  // poll and select handling
  always_comb begin
    clav_hiz_next = !addr_match;
    clav_next     = addr_match && clav_s;
    // selection is taken while enable is high, held while it is low
    sel_next      = link_enb_n_in ? addr_match : sel_reg;
    out_hiz_next  = !sel_next;
  end

  // unit sequencer and output data
  always_comb begin
    soc_next      = 1'b0;
    data_next     = data_reg;
    parity_next   = parity_reg;
    total_next    = 1'b0;
    lane_next     = lane_reg;
    cnt_next      = cnt_reg;
    ack_tgl_next  = ack_tgl_reg;
    underrun_next = sel_reg && !link_enb_n_in && !clav_s && (cnt_reg == URX_CNT_RST);
    if (go) begin
      data_next   = unit;
      parity_next = wide_s ? ~^unit : ~^unit[7:0];
      soc_next    = word_reg.soc && (lane_reg == URX_LANE_RST);
      total_next  = word_reg.soc && (lane_reg == URX_LANE_RST);
      if (cell_end || (lane_reg == last_lane)) begin
        lane_next    = URX_LANE_RST;
        ack_tgl_next = ~ack_tgl_reg;  // hand the word back
      end else begin
        lane_next = lane_reg + 2'h1;
      end
      cnt_next = cell_end ? URX_CNT_RST : cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clav_reg     <= 1'b0;
      clav_hiz_reg <= 1'b1;
      sel_reg      <= 1'b0;
      out_hiz_reg  <= 1'b1;
      soc_reg      <= 1'b0;
      data_reg     <= URX_DATA_RST;
      parity_reg   <= 1'b1;
      total_reg    <= 1'b0;
      underrun_reg <= 1'b0;
      ack_tgl_reg  <= 1'b0;
      lane_reg     <= URX_LANE_RST;
      cnt_reg      <= URX_CNT_RST;
    end else begin
      clav_reg     <= clav_next;
      clav_hiz_reg <= clav_hiz_next;
      sel_reg      <= sel_next;
      out_hiz_reg  <= out_hiz_next;
      soc_reg      <= soc_next;
      data_reg     <= data_next;
      parity_reg   <= parity_next;
      total_reg    <= total_next;
      underrun_reg <= underrun_next;
      ack_tgl_reg  <= ack_tgl_next;
      lane_reg     <= lane_next;
      cnt_reg      <= cnt_next;
    end
  end

  assign clav_hiz_out        = clav_hiz_reg;
  assign link_clav_out       = clav_reg;
  assign bus_outputs_hiz_out = out_hiz_reg;
  assign link_soc_out        = soc_reg;
  assign link_data_out       = data_reg;
  assign link_parity_out     = parity_reg;
  assign total_cell_out      = total_reg;
  assign underrun_out        = underrun_reg;

endmodule
`default_nettype wire

//--- urx_slave_checker.sv
// urx_slave_checker: link and fifo side properties of urx_slave.
// assumes: bound to urx_slave; port address and width inputs static.
`timescale 1ns/1ps
`default_nettype none
module urx_slave_checker
  import urx_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        fifo_read_out,
  input wire logic        link_clk_in,
  input wire logic [4:0]  link_addr_in,
  input wire logic        link_enb_n_in,
  input wire logic [4:0]  port_addr_in,
  input wire logic        clav_hiz_out,
  input wire logic        link_soc_out,
  input wire logic [15:0] link_data_out,
  input wire logic        link_parity_out,
  input wire logic        bus_outputs_hiz_out,
  input wire logic        total_cell_out,
  input wire logic        underrun_out
);
  logic [1:0] warm_reg;
  logic [1:0] warm_next;
  // link edges since reset, config is settled by the third
  always_comb warm_next = (warm_reg == 2'h3) ? warm_reg : warm_reg + 2'h1;
  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) warm_reg <= 2'h0;
    else warm_reg <= warm_next;
  end
  logic       cold;
  // link properties wait until the synchronised config has settled
  assign cold = !resetn_in || (warm_reg != 2'h3);
  sequence idle_s; link_enb_n_in; endsequence
  sequence held_s; $stable(link_data_out) && !link_soc_out; endsequence
  sequence hit_s; link_enb_n_in && link_addr_in == port_addr_in; endsequence
  no_move_a: assert property (@(posedge link_clk_in) disable iff (cold)
    idle_s |=> held_s) else $error("unit while idle");
  odd_par_a: assert property (@(posedge link_clk_in) disable iff (cold)
    link_parity_out == ~^link_data_out) else $error("parity");
  soc_total_a: assert property (@(posedge link_clk_in) disable iff (cold)
    link_soc_out == total_cell_out) else $error("total");
  soc_once_a: assert property (@(posedge link_clk_in) disable iff (cold)
    link_soc_out |=> !link_soc_out) else $error("soc long");
  soc_drive_a: assert property (@(posedge link_clk_in) disable iff (cold)
    link_soc_out |-> !bus_outputs_hiz_out) else $error("soc hiz");
  addr_miss_a: assert property (@(posedge link_clk_in) disable iff (cold)
    link_addr_in != port_addr_in |=> clav_hiz_out) else $error("miss");
  addr_hit_a: assert property (@(posedge link_clk_in) disable iff (cold)
    hit_s |=> !clav_hiz_out && !bus_outputs_hiz_out) else $error("hit");
  under_sel_a: assert property (@(posedge link_clk_in) disable iff (cold)
    $rose(underrun_out) |-> !$past(link_enb_n_in)) else $error("under");
  read_once_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fifo_read_out |=> !fifo_read_out) else $error("read long");
endmodule
bind urx_slave urx_slave_checker chk_u (.clk_in, .resetn_in, .fifo_read_out, .link_clk_in,
  .link_addr_in, .link_enb_n_in, .port_addr_in, .clav_hiz_out, .link_soc_out, .link_data_out,
  .link_parity_out, .bus_outputs_hiz_out, .total_cell_out, .underrun_out);
`default_nettype wire

//--- urx_fifo_model.sv
// urx_fifo_model: show-ahead cell fifo feeding urx_slave on clk_in.
// assumes: bench pushes whole cells into q and bumps cells after each.
`timescale 1ns/1ps
`default_nettype none
module urx_fifo_model
  import urx_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      read_in,
  output var logic       clav_out,
  output var urx_word_t  word_out
);
  urx_word_t q[$];
  int        cells = 0;
  initial clav_out = 1'b0;
  initial word_out = URX_WORD_RST;
  // word per read, flags with data
  always @(posedge clk_in) begin
    if (read_in && q.size() > 0) begin
      if (q[0].soc) cells--;
      void'(q.pop_front());
    end
    clav_out <= cells > 0;
    if (q.size() > 0) word_out <= q[0];
    else word_out <= '{data: ~word_out.data, soc: 1'b0, eoc: 1'b0};
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// tb_top: fifo model and link master around urx_slave, unit by unit compare.
// assumes: urx_fifo_model and urx_slave_checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import urx_pkg::*;
  logic        clk_in = 1'b0;
  logic        link_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        link_enb_n_in = 1'b1;
  logic        wide_bus_in = 1'b0;
  logic [4:0]  link_addr_in = 5'h00;
  logic [4:0]  port_addr_in = 5'h15;
  logic        fifo_read_out, fifo_clav_in, link_clav_out, clav_hiz_out, link_soc_out;
  logic        link_parity_out, bus_outputs_hiz_out, total_cell_out, underrun_out;
  logic [15:0] link_data_out, last_data;
  urx_word_t   fifo_word;
  int          fails = 0, checks = 0, cells = 0, cycles = 0;
  logic [16:0] exp_q[$];
  logic [16:0] mon_want;
  // two unrelated clocks
  initial forever #10 clk_in = ~clk_in;
  initial begin #7; forever #32 link_clk_in = ~link_clk_in; end
  urx_fifo_model fm_u (.clk_in, .read_in(fifo_read_out), .clav_out(fifo_clav_in),
    .word_out(fifo_word));
  urx_slave dut_u (.clk_in, .resetn_in, .fifo_clav_in, .fifo_data_in(fifo_word.data),
    .fifo_soc_in(fifo_word.soc), .fifo_eoc_in(fifo_word.eoc), .fifo_read_out, .link_clk_in,
    .link_addr_in, .link_enb_n_in, .port_addr_in, .wide_bus_in, .link_clav_out, .clav_hiz_out,
    .link_soc_out, .link_data_out, .link_parity_out, .bus_outputs_hiz_out, .total_cell_out,
    .underrun_out);
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  // unit monitor: a changed or soc-marked value is a new unit
  always @(posedge link_clk_in) begin
    if (resetn_in && !bus_outputs_hiz_out && (link_soc_out || link_data_out !== last_data)) begin
      mon_want = exp_q.size() ? exp_q.pop_front() : 17'hx;
      check({link_soc_out, link_data_out}, mon_want);
      check(17'(link_parity_out), 17'(~^mon_want[15:0]));
    end
    if (resetn_in && total_cell_out) cells++;
    last_data = link_data_out;
  end
  // cells of adjacent-distinct units, packed msb first into words
  task automatic push_cells(input int n);
    int ub, per, nu, d, w;
    ub = wide_bus_in ? 16 : 8;
    per = 32 / ub;
    nu = wide_bus_in ? 27 : 53;
    d = 0;
    for (int c = 0; c < n; c++) begin
      for (int k = 0; k < 14 * per; k++) begin
        d = (d ^ (($urandom % ((1 << ub) - 1)) + 1)) & ((1 << ub) - 1);
        w = (w << ub) | d;
        if (k < nu) exp_q.push_back({k == 0, 16'(d)});
        if (k % per == per - 1)
          fm_u.q.push_back('{data: 32'(w), soc: k < per, eoc: k >= 13 * per});
      end
      fm_u.cells++;
    end
  endtask
  task automatic link_run(input int n, input logic rnd);
    repeat (n) begin
      @(posedge link_clk_in);
      #1 link_enb_n_in = rnd ? ($urandom % 4 == 0) : 1'b0;
    end
  endtask
  // one width mode from reset to two transferred cells
  task automatic phase(input logic wide);
    @(posedge clk_in);
    #1 resetn_in = 1'b0;
    wide_bus_in = wide;
    port_addr_in = 5'($urandom);
    link_addr_in = ~port_addr_in;
    link_enb_n_in = 1'b1;
    fm_u.q.delete();
    fm_u.cells = 0;
    exp_q.delete();
    cells = 0;
    repeat (6) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (4) @(posedge link_clk_in);
    #1 check(17'(clav_hiz_out), 17'h1);
    link_addr_in = port_addr_in;
    repeat (2) @(posedge link_clk_in);
    #1 check(17'({clav_hiz_out, link_clav_out}), 17'h0);
    link_run(3, 1'b0);
    check(17'(underrun_out), 17'h1);
    @(posedge link_clk_in);
    #1 link_enb_n_in = 1'b1;
    push_cells(2);
    repeat (6) @(posedge link_clk_in);
    #1 check(17'(link_clav_out), 17'h1);
    check(17'(underrun_out), 17'h0);
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) link_run(1, 1'b1);
    check(17'(cells), 17'h2);
    check(17'(exp_q.size()), 17'h0);
  endtask
  initial begin
    void'($urandom(32'h8186));
    phase(1'b0);
    phase(1'b1);
    results();
  end
endmodule
`default_nettype wire
